// [nblse_pkg.sv]
// ====
// Shared constants for the block-lock, status and ECC control block
// ====
package nblse_pkg;

    // ====
    // Command opcodes
    // ====
    localparam logic [7:0] OP_SET_FEAT   = 8'h1f;
    localparam logic [7:0] OP_GET_FEAT   = 8'h0f;
    localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_PROG_EXEC  = 8'h10;
    localparam logic [7:0] OP_PAGE_READ  = 8'h13;
    localparam logic [7:0] OP_BLK_ERASE  = 8'hd8;
    localparam logic [7:0] OP_RESET      = 8'hff;

    // ====
    // Feature addresses
    // ====
    localparam logic [7:0] FA_BLOCK_PROT  = 8'ha0;
    localparam logic [7:0] FA_FEATURE_CFG = 8'hb0;
    localparam logic [7:0] FA_OP_STATUS   = 8'hc0;

    // ====
    // block_protection_control fields
    // ====
    localparam int PROT_LOCK_PIN_BIT = 7;
    localparam int PROT_RANGE_LSB    = 3;
    localparam int PROT_INVERT_BIT   = 2;
    localparam int PROT_COMPL_BIT    = 1;
    localparam logic [7:0] PROT_RST  = 8'h38;

    // ====
    // Feature configuration fields
    // ====
    localparam int CFG_ECC_ON_BIT   = 4;
    localparam logic [7:0] CFG_RST  = 8'h10;

    // ====
    // operation_status fields
    // ====
    localparam int ST_ECC_LSB     = 4;
    localparam int ST_PFAIL_BIT   = 3;
    localparam int ST_EFAIL_BIT   = 2;
    localparam int ST_WEL_BIT     = 1;
    localparam int ST_BUSY_BIT    = 0;
    localparam logic [7:0] ST_RST = 8'h01;

    // ====
    // ECC result codes
    // ====
    localparam logic [1:0] ECC_NONE    = 2'h0;
    localparam logic [1:0] ECC_FIXED_7 = 2'h1;
    localparam logic [1:0] ECC_UNCORR  = 2'h2;
    localparam logic [1:0] ECC_FIXED_8 = 2'h3;

    // Row of the power-on page read (block 0, page 0)
    localparam logic [15:0] POR_ROW = 16'h0000;

    typedef enum logic [1:0] {
        ARR_READ,
        ARR_PROG,
        ARR_ERASE,
        ARR_RESET
    } nblse_arr_op_t;

endpackage

// [nblse_ctrl.sv]
// Overview of operation
// RULE1: Power-up leaves all range bits 1, invert, complement, pin-lock 0.
// RULE2: Pin-lock set with write-protect pin low refuses any protection change.
// RULE3: Program or erase to a locked block starts nothing; busy stays 0.
// RULE4: Erase to a locked block reports erase failure, status 04h.
// RULE5: Program to a locked block reports program failure, status 08h.
// RULE6: Range 000 unlocks everything, 111 locks everything and is default.
// RULE7: Plain codes 001..110 lock upper 1/64 to 1/2 of rows.
// RULE8: Invert codes 001..110 lock lower 1/64 to 1/2 of rows.
// RULE9: Complement locks lower 63/64 to 3/4; code 110 locks block zero only.
// RULE10: Complement with invert locks upper 63/64 to 3/4 of rows.
// RULE11: Host changes protection by feature-write to address A0h.
// RULE12: Eight-bit status readable by feature-read at address C0h.
// RULE13: Program failure flag set on failure or lock; cleared by program-execute or reset.
// RULE14: Erase failure flag set on failure or lock; cleared by erase start or reset.
// RULE15: Write-enable latch set by write-enable, cleared by write-disable.
// RULE16: Busy reads 1 during program, page read, erase or reset.
// RULE17: ECC result: 00 clean, 01 1-7 fixed, 10 uncorrected, 11 8 fixed.
// RULE18: ECC result clears at reset and read start, updates at read end.
// RULE19: ECC enabled at power-up; feature-write of ecc_on sets it to the written bit.
// RULE20: With ECC on, array engine encodes on program and corrects on read.
// RULE21: With ECC on, host writes to spare parity bytes are dropped.
// RULE22: Host screens factory bad-block marks before program or erase.
// RULE23: Program and erase rows are 16-bit after 8 dummy bits.
// RULE24: Program or erase without write-enable latch is ignored.
// RULE25: Lock decode is combinational and checked before starting the array.
// RULE26: Undefined protection codes lock the whole array.
`timescale 1ns/10ps
`default_nettype none

module nblse_ctrl (
    input  wire logic                  i_clk_sys,       // System clock, 100 MHz
    input  wire logic                  i_sys_rst,       // Synchronous reset, high
    input  wire logic                  i_ce,            // Clock enable for system domain
    input  wire logic                  i_wp_n,          // Write-protect pin, async
    input  wire logic                  i_sck,           // Serial link clock
    input  wire logic                  i_lnk_cmd_vld,   // Decoded command strobe
    input  wire logic [7:0]            i_lnk_opcode,    // Command opcode
    input  wire logic [7:0]            i_lnk_feat_addr, // Feature address
    input  wire logic [7:0]            i_lnk_feat_wdata,// Feature write data
    input  wire logic [15:0]           i_lnk_row,       // Row address
    input  wire logic                  i_lnk_load_vld,  // Cache load byte strobe
    input  wire logic [11:0]           i_lnk_load_col,  // Cache load column
    input  wire logic                  i_arr_done,      // Array operation finished
    input  wire logic                  i_arr_fail,      // Program or erase failed
    input  wire logic [1:0]            i_arr_ecc,       // ECC outcome of a read
    output logic [7:0]                 o_lnk_feat_rdata,// Feature read data
    output logic                       o_lnk_load_keep, // Load byte may be stored
    output logic                       o_arr_start,     // Array operation start pulse
    output nblse_pkg::nblse_arr_op_t   o_arr_op,        // Array operation kind
    output logic [15:0]                o_arr_row,       // Array row address
    output logic                       o_ecc_en         // Internal ECC enable
);

    // ====
    // Protection decode
    // ====
    function automatic logic row_locked(input logic [2:0]  range_code,
                                        input logic        range_invert,
                                        input logic        range_complement,
                                        input logic [15:0] row);
        logic [5:0] mask;
        logic       upper_hit;
        logic       lower_hit;
        mask = 6'h00;
        unique case (range_code)
            3'h1:    mask = 6'h3f;
            3'h2:    mask = 6'h3e;
            3'h3:    mask = 6'h3c;
            3'h4:    mask = 6'h38;
            3'h5:    mask = 6'h30;
            3'h6:    mask = 6'h20;
            default: mask = 6'h00;
        endcase
        upper_hit = (row[15:10] | ~mask) == 6'h3f;
        lower_hit = (row[15:10] & mask) == 6'h00;
        if (range_code == 3'h0) begin
            row_locked = 1'b0;                                 // [RULE6]
        end else if (range_code == 3'h7) begin
            row_locked = 1'b1;                                 // [RULE6]
        end else if (range_complement && range_code == 3'h6) begin
            row_locked = row[15:6] == 10'h000;                 // [RULE9]
        end else begin
            unique case ({range_complement, range_invert})
                2'b00:   row_locked = upper_hit;               // [RULE7]
                2'b01:   row_locked = lower_hit;               // [RULE8]
                2'b10:   row_locked = !upper_hit;              // [RULE9]
                2'b11:   row_locked = !lower_hit;              // [RULE10]
                default: row_locked = 1'b1;                    // [RULE26]
            endcase
        end
    endfunction

    // Spare parity bytes 80Ch-80Fh, 81Ch-81Fh, 82Ch-82Fh, 83Ch-83Fh
    function automatic logic is_parity_col(input logic [11:0] col);
        is_parity_col = (col[11:6] == 6'h20) && (col[3:2] == 2'h3);
    endfunction

    // ====
    // Link domain: reset sync and command capture
    // ====
    logic        lrst_s1_r;
    logic        lrst_r;
    logic        cmd_tgl_r;
    logic [7:0]  cmd_op_r;
    logic [7:0]  cmd_fa_r;
    logic [7:0]  cmd_wd_r;
    logic [15:0] cmd_row_r;

    always_ff @(posedge i_sck) begin
        lrst_s1_r <= i_sys_rst;
        lrst_r    <= lrst_s1_r;
    end

    // Hold registers stay stable until the next command
    always_ff @(posedge i_sck) begin
        if (lrst_r) begin
            cmd_tgl_r <= 1'b0;
            cmd_op_r  <= 8'h00;
            cmd_fa_r  <= 8'h00;
            cmd_wd_r  <= 8'h00;
            cmd_row_r <= 16'h0000;
        end else if (i_lnk_cmd_vld && i_lnk_opcode != nblse_pkg::OP_GET_FEAT) begin
            cmd_tgl_r <= ~cmd_tgl_r;
            cmd_op_r  <= i_lnk_opcode;
            cmd_fa_r  <= i_lnk_feat_addr;
            cmd_wd_r  <= i_lnk_feat_wdata;
            cmd_row_r <= i_lnk_row;                            // [RULE23]
        end
    end

    // ====
    // Link domain: mirrors of system state
    // ====
    logic [23:0] pub_data_r;
    logic        pub_req_r;
    logic        lreq_s1_r;
    logic        lreq_s2_r;
    logic        lreq_s3_r;
    logic [7:0]  mir_prot_r;
    logic [7:0]  mir_cfg_r;
    logic [7:0]  mir_stat_r;

    always_ff @(posedge i_sck) begin
        if (lrst_r) begin
            lreq_s1_r <= 1'b0;
            lreq_s2_r <= 1'b0;
            lreq_s3_r <= 1'b0;
        end else begin
            lreq_s1_r <= pub_req_r;
            lreq_s2_r <= lreq_s1_r;
            lreq_s3_r <= lreq_s2_r;
        end
    end

    always_ff @(posedge i_sck) begin
        if (lrst_r) begin
            mir_cfg_r  <= nblse_pkg::CFG_RST;
            mir_prot_r <= nblse_pkg::PROT_RST;
            mir_stat_r <= nblse_pkg::ST_RST;
        end else if (lreq_s2_r != lreq_s3_r) begin
            mir_cfg_r  <= pub_data_r[23:16];
            mir_prot_r <= pub_data_r[15:8];
            mir_stat_r <= pub_data_r[7:0];
        end
    end

    // ====
    // Link domain: feature read and load filter
    // ====
    always_ff @(posedge i_sck) begin
        if (lrst_r) begin
            o_lnk_feat_rdata <= 8'h00;
        end else if (i_lnk_cmd_vld && i_lnk_opcode == nblse_pkg::OP_GET_FEAT) begin
            unique case (i_lnk_feat_addr)
                nblse_pkg::FA_BLOCK_PROT:  o_lnk_feat_rdata <= mir_prot_r;
                nblse_pkg::FA_FEATURE_CFG: o_lnk_feat_rdata <= mir_cfg_r;
                nblse_pkg::FA_OP_STATUS:   o_lnk_feat_rdata <= mir_stat_r; // [RULE12]
                default:                   o_lnk_feat_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_sck) begin
        if (lrst_r) begin
            o_lnk_load_keep <= 1'b1;
        end else if (i_lnk_load_vld) begin
            o_lnk_load_keep <= !(mir_cfg_r[nblse_pkg::CFG_ECC_ON_BIT]
                                 && is_parity_col(i_lnk_load_col)); // [RULE21]
        end
    end

    // ====
    // System domain: synchronisers
    // ====
    logic wp_s1_r;
    logic wp_n_r;
    logic ctg_s1_r;
    logic ctg_s2_r;
    logic ctg_s3_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic cmd_evt;

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            wp_s1_r  <= 1'b1;
            wp_n_r   <= 1'b1;
            ctg_s1_r <= 1'b0;
            ctg_s2_r <= 1'b0;
            ctg_s3_r <= 1'b0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else if (i_ce) begin
            wp_s1_r  <= i_wp_n;
            wp_n_r   <= wp_s1_r;
            ctg_s1_r <= cmd_tgl_r;
            ctg_s2_r <= ctg_s1_r;
            ctg_s3_r <= ctg_s2_r;
            ack_s1_r <= lreq_s3_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    assign cmd_evt = ctg_s2_r != ctg_s3_r;

    // ====
    // System domain: command decode
    // ====
    typedef enum logic [1:0] {
        NBLSE_IDLE,
        NBLSE_START,
        NBLSE_BUSY
    } nblse_state_t;

    nblse_state_t state_r;
    logic [7:0]   prot_r;
    logic [7:0]   cfg_r;
    logic         wel_r;
    logic         pfail_r;
    logic         efail_r;
    logic [1:0]   ecc_res_r;
    logic         busy;
    logic         is_set_feat;
    logic         is_wr_op;
    logic         wr_granted;
    logic         target_locked;
    logic         do_reset;
    logic         do_read;
    logic         fail_done;

    assign busy          = state_r != NBLSE_IDLE;
    assign is_set_feat   = cmd_evt && cmd_op_r == nblse_pkg::OP_SET_FEAT;
    assign is_wr_op      = cmd_evt && !busy
                           && (cmd_op_r == nblse_pkg::OP_PROG_EXEC
                               || cmd_op_r == nblse_pkg::OP_BLK_ERASE);
    assign wr_granted    = is_wr_op && wel_r;                  // [RULE24]
    assign target_locked = row_locked(prot_r[nblse_pkg::PROT_RANGE_LSB +: 3],
                                      prot_r[nblse_pkg::PROT_INVERT_BIT],
                                      prot_r[nblse_pkg::PROT_COMPL_BIT],
                                      cmd_row_r);              // [RULE25]
    assign do_reset      = cmd_evt && cmd_op_r == nblse_pkg::OP_RESET;
    assign do_read       = cmd_evt && !busy && cmd_op_r == nblse_pkg::OP_PAGE_READ;
    assign fail_done     = i_arr_done && state_r == NBLSE_BUSY && i_arr_fail;

    // ====
    // System domain: feature registers
    // ====
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            prot_r <= nblse_pkg::PROT_RST;                     // [RULE1]
        end else if (i_ce && is_set_feat && cmd_fa_r == nblse_pkg::FA_BLOCK_PROT) begin
            if (!(prot_r[nblse_pkg::PROT_LOCK_PIN_BIT] && !wp_n_r)) begin
                prot_r <= cmd_wd_r & 8'hbe;                    // [RULE2] [RULE11]
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cfg_r <= nblse_pkg::CFG_RST;                       // [RULE19]
        end else if (i_ce && is_set_feat && cmd_fa_r == nblse_pkg::FA_FEATURE_CFG) begin
            cfg_r[nblse_pkg::CFG_ECC_ON_BIT] <= cmd_wd_r[nblse_pkg::CFG_ECC_ON_BIT]; // [RULE19]
        end
    end

    // ====
    // System domain: status flags
    // ====
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || (i_ce && do_reset)) begin
            wel_r <= 1'b0;
        end else if (i_ce && cmd_evt) begin
            if (cmd_op_r == nblse_pkg::OP_WR_ENABLE) begin
                wel_r <= 1'b1;                                 // [RULE15]
            end else if (cmd_op_r == nblse_pkg::OP_WR_DISABLE || wr_granted) begin
                wel_r <= 1'b0;                                 // [RULE15]
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || (i_ce && do_reset)) begin
            pfail_r <= 1'b0;                                   // [RULE13]
        end else if (i_ce) begin
            if (wr_granted && cmd_op_r == nblse_pkg::OP_PROG_EXEC) begin
                pfail_r <= target_locked;                      // [RULE5] [RULE13]
            end else if (fail_done && o_arr_op == nblse_pkg::ARR_PROG) begin
                pfail_r <= 1'b1;                               // [RULE13]
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || (i_ce && do_reset)) begin
            efail_r <= 1'b0;                                   // [RULE14]
        end else if (i_ce) begin
            if (wr_granted && cmd_op_r == nblse_pkg::OP_BLK_ERASE) begin
                efail_r <= target_locked;                      // [RULE4] [RULE14]
            end else if (fail_done && o_arr_op == nblse_pkg::ARR_ERASE) begin
                efail_r <= 1'b1;                               // [RULE14]
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || (i_ce && (do_reset || do_read))) begin
            ecc_res_r <= nblse_pkg::ECC_NONE;                  // [RULE18]
        end else if (i_ce && i_arr_done && state_r == NBLSE_BUSY
                     && o_arr_op == nblse_pkg::ARR_READ) begin
            ecc_res_r <= o_ecc_en ? i_arr_ecc : nblse_pkg::ECC_NONE; // [RULE17] [RULE18]
        end
    end

    // ====
    // System domain: array sequencer
    // ====
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_r     <= NBLSE_START;                        // [RULE16]
            o_arr_op    <= nblse_pkg::ARR_READ;
            o_arr_row   <= nblse_pkg::POR_ROW;
            o_arr_start <= 1'b0;
            o_ecc_en    <= 1'b1;
        end else if (i_ce) begin
            o_arr_start <= 1'b0;
            if (do_reset) begin
                state_r  <= NBLSE_START;                       // [RULE16]
                o_arr_op <= nblse_pkg::ARR_RESET;
            end else begin
                unique case (state_r)
                    NBLSE_IDLE: begin
                        o_ecc_en <= cfg_r[nblse_pkg::CFG_ECC_ON_BIT]; // [RULE20]
                        if (do_read) begin
                            state_r   <= NBLSE_START;
                            o_arr_op  <= nblse_pkg::ARR_READ;
                            o_arr_row <= cmd_row_r;
                        end else if (wr_granted && !target_locked) begin // [RULE3]
                            state_r   <= NBLSE_START;
                            o_arr_op  <= (cmd_op_r == nblse_pkg::OP_PROG_EXEC)
                                         ? nblse_pkg::ARR_PROG : nblse_pkg::ARR_ERASE;
                            o_arr_row <= cmd_row_r;
                        end
                    end
                    NBLSE_START: begin
                        o_arr_start <= 1'b1;
                        state_r     <= NBLSE_BUSY;
                    end
                    NBLSE_BUSY: begin
                        if (i_arr_done) begin
                            state_r <= NBLSE_IDLE;             // [RULE16]
                        end
                    end
                endcase
            end
        end
    end

    // ====
    // System domain: publish state to the link side
    // ====
    logic [23:0] snap;

    assign snap = {cfg_r, prot_r, 2'b00, ecc_res_r, pfail_r, efail_r, wel_r, busy}; // [RULE12]

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pub_req_r  <= 1'b0;
            pub_data_r <= {nblse_pkg::CFG_RST, nblse_pkg::PROT_RST, nblse_pkg::ST_RST};
        end else if (i_ce && ack_s2_r == pub_req_r && snap != pub_data_r) begin
            pub_data_r <= snap;
            pub_req_r  <= ~pub_req_r;
        end
    end

endmodule

`default_nettype wire

// [nblse_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module nblse_checker (
    input wire logic        i_clk_sys, i_sys_rst, i_sck, i_lnk_cmd_vld, i_lnk_load_vld,
    input wire logic [7:0]  i_lnk_opcode, i_lnk_feat_addr, o_lnk_feat_rdata,
    input wire logic [11:0] i_lnk_load_col,
    input wire logic [15:0] o_arr_row,
    input wire logic        o_lnk_load_keep, o_arr_start, o_ecc_en,
    input wire nblse_pkg::nblse_arr_op_t o_arr_op
);
    wire par = i_lnk_load_col[11:6] == 6'h20 && i_lnk_load_col[3:2] == 2'h3;
    a_start_pulse: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        o_arr_start |=> !o_arr_start) else $error("start pulse too long");
    a_por_read: assert property (@(posedge i_clk_sys) $fell(i_sys_rst) |-> ##[1:2]
        (o_arr_start && o_arr_op == nblse_pkg::ARR_READ && o_arr_row == nblse_pkg::POR_ROW))
        else $error("no power-on read");
    a_ecc_reset: assert property (@(posedge i_clk_sys) i_sys_rst ##1 i_sys_rst |->
        o_ecc_en && !o_arr_start) else $error("bad reset outputs");
    a_rdata_hold: assert property (@(posedge i_sck) disable iff (i_sys_rst)
        !i_lnk_cmd_vld |=> $stable(o_lnk_feat_rdata)) else $error("read data moved");
    a_keep_hold: assert property (@(posedge i_sck) disable iff (i_sys_rst)
        !i_lnk_load_vld |=> $stable(o_lnk_load_keep)) else $error("keep moved");
    a_parity_drop: assert property (@(posedge i_sck) disable iff (i_sys_rst)
        i_lnk_load_vld && par && o_ecc_en |=> !o_lnk_load_keep) else $error("parity kept");
    a_data_keep: assert property (@(posedge i_sck) disable iff (i_sys_rst)
        i_lnk_load_vld && !(par && o_ecc_en) |=> o_lnk_load_keep) else $error("data dropped");
    a_unknown_feat: assert property (@(posedge i_sck) disable iff (i_sys_rst)
        i_lnk_cmd_vld && i_lnk_opcode == nblse_pkg::OP_GET_FEAT && i_lnk_feat_addr[7:4] == 4'hd
        |=> o_lnk_feat_rdata == 8'h00) else $error("unknown address not zero");
    c_prog: cover property (@(posedge i_clk_sys) o_arr_start && o_arr_op == nblse_pkg::ARR_PROG);
    c_rst: cover property (@(posedge i_clk_sys) o_arr_start && o_arr_op == nblse_pkg::ARR_RESET);
    c_drop: cover property (@(posedge i_sck) i_lnk_load_vld && par && o_ecc_en);
endmodule
bind nblse_ctrl nblse_checker u_nblse_checker (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_sck(i_sck), .i_lnk_cmd_vld(i_lnk_cmd_vld), .i_lnk_load_vld(i_lnk_load_vld),
    .i_lnk_opcode(i_lnk_opcode), .i_lnk_feat_addr(i_lnk_feat_addr),
    .o_lnk_feat_rdata(o_lnk_feat_rdata), .i_lnk_load_col(i_lnk_load_col),
    .o_arr_row(o_arr_row), .o_lnk_load_keep(o_lnk_load_keep), .o_arr_start(o_arr_start),
    .o_ecc_en(o_ecc_en), .o_arr_op(o_arr_op));
`default_nettype wire

// [nblse_arr_model.sv]
`timescale 1ns/10ps
`default_nettype none
module nblse_arr_model (
    input  wire logic       i_clk_sys,  // System clock
    input  wire logic       i_sys_rst,  // Reset
    input  wire logic       i_start,    // Start pulse
    input  wire logic [7:0] i_lat,      // Cycles until done
    input  wire logic       i_fail_cmd, // Report failure
    input  wire logic [1:0] i_ecc_cmd,  // ECC code to report
    output logic            o_done,     // Done pulse
    output logic            o_fail,     // Failure with done
    output logic [1:0]      o_ecc       // ECC code with done
);
    logic [7:0] cnt_r;
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst)
            cnt_r <= 8'h00;
        else if (i_start)
            cnt_r <= i_lat;
        else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
    end
    assign o_done = cnt_r == 8'h01;
    assign o_fail = o_done & i_fail_cmd;
    // Outside done the code is garbage on purpose
    assign o_ecc = o_done ? i_ecc_cmd : ~i_ecc_cmd;
endmodule
`default_nettype wire

// [tb_nblse_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_nblse_ctrl;
    logic clk = 1'b0, sck = 1'b0, rst = 1'b1, wp_n = 1'b1, vld = 1'b0, ldv = 1'b0, fl = 1'b0;
    logic [7:0] op = 8'h00, fa = 8'h00, fd = 8'h00, lat = 8'hc8, rdata;
    logic [15:0] row = 16'h0000, arow;
    logic [11:0] col = 12'h000;
    logic [1:0] ecc = 2'h1, aecc;
    logic keep, start, ecc_en, done, afail;
    nblse_pkg::nblse_arr_op_t aop;
    int n_mismatch = 0, tests_run = 0, n_start = 0, s, i;
    logic [24:0] tbl [14] = '{{8'h00, 16'hffff, 1'b0}, {8'h08, 16'hfc00, 1'b1},
        {8'h08, 16'hfbff, 1'b0}, {8'h30, 16'h8000, 1'b1}, {8'h30, 16'h7fff, 1'b0},
        {8'h0c, 16'h03ff, 1'b1}, {8'h0c, 16'h0400, 1'b0}, {8'h0a, 16'hfbff, 1'b1},
        {8'h0a, 16'hfc00, 1'b0}, {8'h32, 16'h0040, 1'b0}, {8'h36, 16'h003f, 1'b1},
        {8'h2e, 16'h3fff, 1'b0}, {8'h2e, 16'h4000, 1'b1}, {8'h3e, 16'h0000, 1'b1}};
    initial forever #5 clk = ~clk;
    initial begin
        #3;
        forever #40 sck = ~sck;
    end
    always @(posedge clk) if (start) n_start++;
    nblse_ctrl u_nblse_ctrl (.i_clk_sys(clk), .i_sys_rst(rst), .i_ce(1'b1), .i_wp_n(wp_n),
        .i_sck(sck), .i_lnk_cmd_vld(vld), .i_lnk_opcode(op), .i_lnk_feat_addr(fa),
        .i_lnk_feat_wdata(fd), .i_lnk_row(row), .i_lnk_load_vld(ldv), .i_lnk_load_col(col),
        .i_arr_done(done), .i_arr_fail(afail), .i_arr_ecc(aecc), .o_lnk_feat_rdata(rdata),
        .o_lnk_load_keep(keep), .o_arr_start(start), .o_arr_op(aop), .o_arr_row(arow),
        .o_ecc_en(ecc_en));
    nblse_arr_model u_nblse_arr_model (.i_clk_sys(clk), .i_sys_rst(rst), .i_start(start),
        .i_lat(lat), .i_fail_cmd(fl), .i_ecc_cmd(ecc), .o_done(done), .o_fail(afail),
        .o_ecc(aecc));
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] v, input logic [15:0] e);
        tests_run++;
        if (v !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, v, e);
        end
    endtask
    task automatic cmd(input logic [7:0] o, input logic [7:0] a, input logic [7:0] d,
                       input logic [15:0] r);
        @(posedge sck);
        vld <= 1'b1;
        op <= o;
        fa <= a;
        fd <= d;
        row <= r;
        @(posedge sck);
        vld <= 1'b0;
        repeat (5) @(posedge sck);
    endtask
    task automatic gf(input logic [7:0] a, input logic [7:0] e);
        cmd(nblse_pkg::OP_GET_FEAT, a, 8'h00, 16'h0000);
        chk(rdata, e);
    endtask
    task automatic rdy;
        for (int k = 0; k < 40; k++) begin
            cmd(nblse_pkg::OP_GET_FEAT, nblse_pkg::FA_OP_STATUS, 8'h00, 16'h0000);
            if (rdata[0] === 1'b0) return;
        end
        n_mismatch++;
        close_out;
    endtask
    task automatic ld(input logic [11:0] c, input logic e);
        @(posedge sck);
        ldv <= 1'b1;
        col <= c;
        @(posedge sck);
        ldv <= 1'b0;
        @(posedge sck);
        chk(keep, e);
    endtask
    task automatic tp(input logic [7:0] a0, input logic [15:0] r, input logic lk);
        cmd(nblse_pkg::OP_SET_FEAT, nblse_pkg::FA_BLOCK_PROT, a0, 16'h0000);
        cmd(nblse_pkg::OP_WR_ENABLE, 8'h00, 8'h00, 16'h0000);
        s = n_start;
        cmd(nblse_pkg::OP_PROG_EXEC, 8'h00, 8'h00, r);
        rdy;
        chk(16'(n_start - s), {15'h0000, !lk});
        if (!lk) chk(arow, r);
        gf(nblse_pkg::FA_OP_STATUS, {4'h0, lk | fl, 3'h4});
    endtask
    initial begin
        repeat (4) @(posedge sck);
        @(posedge clk) rst <= 1'b0;
        repeat (3) @(posedge sck);
        gf(nblse_pkg::FA_OP_STATUS, 8'h01);
        lat <= 8'h14;
        rdy;
        gf(nblse_pkg::FA_OP_STATUS, 8'h10);
        gf(nblse_pkg::FA_BLOCK_PROT, 8'h38);
        gf(nblse_pkg::FA_FEATURE_CFG, 8'h10);
        gf(8'hd0, 8'h00);
        $display("test power-up done");
        cmd(nblse_pkg::OP_RESET, 8'h00, 8'h00, 16'h0000);
        rdy;
        gf(nblse_pkg::FA_OP_STATUS, 8'h00);
        cmd(nblse_pkg::OP_WR_ENABLE, 8'h00, 8'h00, 16'h0000);
        gf(nblse_pkg::FA_OP_STATUS, 8'h02);
        cmd(nblse_pkg::OP_WR_DISABLE, 8'h00, 8'h00, 16'h0000);
        gf(nblse_pkg::FA_OP_STATUS, 8'h00);
        s = n_start;
        cmd(nblse_pkg::OP_BLK_ERASE, 8'h00, 8'h00, 16'h0010);
        gf(nblse_pkg::FA_OP_STATUS, 8'h00);
        cmd(nblse_pkg::OP_WR_ENABLE, 8'h00, 8'h00, 16'h0000);
        cmd(nblse_pkg::OP_BLK_ERASE, 8'h00, 8'h00, 16'h0010);
        gf(nblse_pkg::FA_OP_STATUS, 8'h04);
        chk(16'(n_start - s), 16'h0000);
        $display("test locked block done");
        for (i = 0; i < 14; i++) tp(tbl[i][24:17], tbl[i][16:1], tbl[i][0]);
        fl <= 1'b1;
        tp(8'h00, 16'h0100, 1'b0);
        fl <= 1'b0;
        $display("test ranges done");
        cmd(nblse_pkg::OP_RESET, 8'h00, 8'h00, 16'h0000);
        rdy;
        ecc <= 2'h3;
        for (i = 0; i < 2; i++) begin
            cmd(nblse_pkg::OP_SET_FEAT, nblse_pkg::FA_FEATURE_CFG, i ? 8'h10 : 8'h00, 16'h0000);
            chk(ecc_en, i);
            cmd(nblse_pkg::OP_PAGE_READ, 8'h00, 8'h00, 16'h0005);
            rdy;
            gf(nblse_pkg::FA_OP_STATUS, i ? 8'h30 : 8'h00);
            ld(12'h80c, !i);
            ld(12'h804, 1'b1);
        end
        $display("test ecc done");
        cmd(nblse_pkg::OP_SET_FEAT, nblse_pkg::FA_BLOCK_PROT, 8'hb8, 16'h0000);
        wp_n <= 1'b0;
        cmd(nblse_pkg::OP_SET_FEAT, nblse_pkg::FA_BLOCK_PROT, 8'h00, 16'h0000);
        gf(nblse_pkg::FA_BLOCK_PROT, 8'hb8);
        wp_n <= 1'b1;
        cmd(nblse_pkg::OP_SET_FEAT, nblse_pkg::FA_BLOCK_PROT, 8'h00, 16'h0000);
        gf(nblse_pkg::FA_BLOCK_PROT, 8'h00);
        $display("test pin lock done");
        close_out;
    end
    initial begin
        #1000000;
        n_mismatch++;
        close_out;
    end
endmodule
`default_nettype wire
